// ==== sbs_map.svh ====
// Constants of the burst SRAM read/write link: widths, latencies, reset values.
// Assumes one clock; each pair of clock cycles is one input clock period.
// Contract
// - Separate read-only and write-only data ports
// - Read and write share one address bus
// - Four beats per access over two periods
// - PLL on: read data after 1.5 periods
// - PLL off: read data after one period
// - Accesses launch only on positive input edge
// - Write data captured on both input edges
// - Read data leaves from output registers
// - Port and byte selects registered before use
// - Four 512K by 18 arrays, one address
// - Burst of four sequential words per address
// - Low read select latches read address
// - Lowest word first, one word per edge
// - Read right after a read is ignored
// - Controller launches a read only after the last burst is captured and the FIFO is empty
// - Pending bursts finish after deselect
// - Outputs float after last beat, no waits
// - Single clock mode is a power-on strap
// - PLL off limits operation to 167 MHz
`ifndef SBS_MAP_SVH
`define SBS_MAP_SVH
`define SBS_ADDR_W 19
`define SBS_BEAT_W 18
`define SBS_WORD_W 72
`define SBS_BYTE_W 9
`define SBS_BEATS 3'h4
`define SBS_BWS_W 2
`define SBS_MASK_W 8
`define SBS_LAT_PLL_ON 2'h2
`define SBS_LAT_PLL_OFF 2'h1
`define SBS_FIFO_DEPTH 4
`define SBS_RST_SEL_N 1'h1
`define SBS_RST_BWS_N 2'h3
`define SBS_PLL_OFF_MAX_MHZ 167
`endif

// ==== sbs_pkg.sv ====
// Types shared by both ends of the burst SRAM link.
// Assumes sbs_map.svh is on the include path.
`include "sbs_map.svh"
package sbs_pkg;
  typedef logic [`SBS_ADDR_W-1:0] sbs_addr_type;
  typedef logic [`SBS_BEAT_W-1:0] sbs_beat_type;
  typedef logic [`SBS_WORD_W-1:0] sbs_word_type;
  typedef logic [`SBS_MASK_W-1:0] sbs_mask_type;
  typedef logic [`SBS_BWS_W-1:0] sbs_bws_type;
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_RD = 2'h1,
    ST_WR = 2'h2
  } sbs_state_type;
endpackage : sbs_pkg

// ==== sbs_link_if.sv ====
// Pin-level link between memory controller and burst SRAM.
// Assumes both ends run on core_clk; kEn marks the positive input clock rise.
interface sbs_link_if;
  import sbs_pkg::*;
  logic kEn;
  logic readPortSelectN;
  logic writePortSelectN;
  sbs_bws_type byteWriteSelectN;
  sbs_addr_type addr;
  sbs_beat_type wrBeat;
  sbs_beat_type rdBeat;
  logic rdBeatOe;
  logic pllDisableN;
  logic cStrapHigh;
  modport dev (
    input kEn, readPortSelectN, writePortSelectN, byteWriteSelectN, addr, wrBeat,
    input pllDisableN, cStrapHigh,
    output rdBeat, rdBeatOe
  );
  modport ctl (
    output kEn, readPortSelectN, writePortSelectN, byteWriteSelectN, addr, wrBeat,
    output pllDisableN, cStrapHigh,
    input rdBeat, rdBeatOe
  );
endinterface : sbs_link_if

// ==== sbs_sram_dev.sv ====
// Burst SRAM device end: separate read and write ports, four-beat bursts.
// Assumes the controller drives kEn every second core_clk cycle.
`include "sbs_map.svh"
module sbs_sram_dev (
  // Link
  sbs_link_if.dev link,
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Status
  output logic oneCycleMode,
  output logic singleClkMode,
  output logic rdBusy
);
  import sbs_pkg::*;

  // ************************************************
  // Storage
  // ************************************************
  sbs_word_type mem [0:(1<<`SBS_ADDR_W)-1];

  function automatic sbs_word_type mergeBytes(input sbs_word_type oldW,
                                              input sbs_word_type newW,
                                              input sbs_mask_type maskN);
    sbs_word_type res;
    res = oldW;
    for (int i = 0; i < `SBS_MASK_W; i++) begin
      if (!maskN[i]) begin
        res[i*`SBS_BYTE_W +: `SBS_BYTE_W] = newW[i*`SBS_BYTE_W +: `SBS_BYTE_W];
      end
    end
    return res;
  endfunction : mergeBytes

  // ************************************************
  // Registers
  // ************************************************
  logic pllOff_ff, nxt_pllOff;
  logic sglClk_ff, nxt_sglClk;
  logic rdPrev_ff, nxt_rdPrev;
  logic pendValid_ff, nxt_pendValid;
  logic [1:0] pendWait_ff, nxt_pendWait;
  sbs_addr_type pendAddr_ff, nxt_pendAddr;
  logic [53:0] outShift_ff, nxt_outShift;
  logic [1:0] outCnt_ff, nxt_outCnt;
  sbs_beat_type q_ff, nxt_q;
  logic qOe_ff, nxt_qOe;
  logic wrPrev_ff, nxt_wrPrev;
  logic [2:0] wrCnt_ff, nxt_wrCnt;
  sbs_addr_type wrAddr_ff, nxt_wrAddr;
  logic [53:0] wrData_ff, nxt_wrData;
  logic [5:0] wrMask_ff, nxt_wrMask;
  logic cmtValid_ff, nxt_cmtValid;
  sbs_addr_type cmtAddr_ff, nxt_cmtAddr;
  sbs_word_type cmtData_ff, nxt_cmtData;
  sbs_mask_type cmtMask_ff, nxt_cmtMask;
  logic busy_ff, nxt_busy;

  logic rdLaunch;
  logic wrLaunch;
  logic emit;
  sbs_word_type rdWord;

  // ************************************************
  // Next state
  // ************************************************
  always_comb begin
    // Selects sampled only at the positive input edge
    rdLaunch = link.kEn && !link.readPortSelectN && !rdPrev_ff;
    wrLaunch = link.kEn && !link.writePortSelectN && !wrPrev_ff;
    emit = pendValid_ff && (pendWait_ff == 2'h0);
    rdWord = mem[pendAddr_ff];

    // Straps caught while reset is held
    nxt_pllOff = nrst ? pllOff_ff : !link.pllDisableN;
    nxt_sglClk = nrst ? sglClk_ff : link.cStrapHigh;

    nxt_rdPrev = link.kEn ? rdLaunch : rdPrev_ff;
    nxt_wrPrev = link.kEn ? wrLaunch : wrPrev_ff;

    // Read pending stage
    nxt_pendValid = pendValid_ff;
    nxt_pendWait = pendWait_ff;
    nxt_pendAddr = pendAddr_ff;
    if (rdLaunch) begin
      nxt_pendValid = 1'b1;
      nxt_pendAddr = link.addr;
      nxt_pendWait = pllOff_ff ? `SBS_LAT_PLL_OFF : `SBS_LAT_PLL_ON;
    end else if (emit) begin
      nxt_pendValid = 1'b0;
    end else if (pendValid_ff) begin
      nxt_pendWait = pendWait_ff - 2'h1;
    end

    // Output beats, lowest word first
    nxt_q = q_ff;
    nxt_outShift = outShift_ff;
    nxt_outCnt = outCnt_ff;
    nxt_qOe = 1'b0;
    if (emit) begin
      nxt_q = rdWord[`SBS_BEAT_W-1:0];
      nxt_outShift = rdWord[`SBS_WORD_W-1:`SBS_BEAT_W];
      nxt_outCnt = 2'h3;
      nxt_qOe = 1'b1;
    end else if (outCnt_ff != 2'h0) begin
      nxt_q = outShift_ff[`SBS_BEAT_W-1:0];
      nxt_outShift = {18'h0, outShift_ff[53:`SBS_BEAT_W]};
      nxt_outCnt = outCnt_ff - 2'h1;
      nxt_qOe = 1'b1;
    end else begin
      nxt_q = 18'h0;
    end

    // Write beat capture on every edge of the input clock pair
    nxt_wrAddr = wrAddr_ff;
    nxt_wrData = wrData_ff;
    nxt_wrMask = wrMask_ff;
    nxt_wrCnt = wrCnt_ff;
    nxt_cmtValid = 1'b0;
    nxt_cmtAddr = cmtAddr_ff;
    nxt_cmtData = cmtData_ff;
    nxt_cmtMask = cmtMask_ff;
    if (wrCnt_ff != 3'h0) begin
      nxt_wrData = {link.wrBeat, wrData_ff[53:`SBS_BEAT_W]};
      nxt_wrMask = {link.byteWriteSelectN, wrMask_ff[5:2]};
      nxt_wrCnt = wrCnt_ff - 3'h1;
      if (wrCnt_ff == 3'h1) begin
        nxt_cmtValid = 1'b1;
        nxt_cmtAddr = wrAddr_ff;
        nxt_cmtData = {link.wrBeat, wrData_ff};
        nxt_cmtMask = {link.byteWriteSelectN, wrMask_ff};
      end
    end
    if (wrLaunch) begin
      nxt_wrAddr = link.addr;
      nxt_wrCnt = `SBS_BEATS;
    end

    nxt_busy = nxt_pendValid || (nxt_outCnt != 2'h0) || nxt_qOe;
  end

  // ************************************************
  // Register update
  // ************************************************
  always_ff @(posedge core_clk) begin
    pllOff_ff <= nxt_pllOff;
    sglClk_ff <= nxt_sglClk;
    pendAddr_ff <= nxt_pendAddr;
    outShift_ff <= nxt_outShift;
    wrAddr_ff <= nxt_wrAddr;
    wrData_ff <= nxt_wrData;
    wrMask_ff <= nxt_wrMask;
    cmtAddr_ff <= nxt_cmtAddr;
    cmtData_ff <= nxt_cmtData;
    cmtMask_ff <= nxt_cmtMask;
    if (!nrst) begin
      rdPrev_ff <= 1'b0;
      wrPrev_ff <= 1'b0;
      pendValid_ff <= 1'b0;
      pendWait_ff <= 2'h0;
      outCnt_ff <= 2'h0;
      q_ff <= 18'h0;
      qOe_ff <= 1'b0;
      wrCnt_ff <= 3'h0;
      cmtValid_ff <= 1'b0;
      busy_ff <= 1'b0;
    end else begin
      rdPrev_ff <= nxt_rdPrev;
      wrPrev_ff <= nxt_wrPrev;
      pendValid_ff <= nxt_pendValid;
      pendWait_ff <= nxt_pendWait;
      outCnt_ff <= nxt_outCnt;
      q_ff <= nxt_q;
      qOe_ff <= nxt_qOe;
      wrCnt_ff <= nxt_wrCnt;
      cmtValid_ff <= nxt_cmtValid;
      busy_ff <= nxt_busy;
    end
  end

  // Array write with byte merge
  always_ff @(posedge core_clk) begin
    if (cmtValid_ff) begin
      mem[cmtAddr_ff] <= mergeBytes(mem[cmtAddr_ff], cmtData_ff, cmtMask_ff);
    end
  end

  // ************************************************
  // Outputs
  // ************************************************
  assign link.rdBeat = q_ff;
  assign link.rdBeatOe = qOe_ff;
  assign oneCycleMode = pllOff_ff;
  assign singleClkMode = sglClk_ff;
  assign rdBusy = busy_ff;
endmodule : sbs_sram_dev

// ==== sbs_mem_ctrl.sv ====
// Memory controller end with read-data FIFO toward the user.
// Assumes one core_clk; the input clock rise is a divided enable.
`include "sbs_map.svh"
module sbs_fifo #(
  parameter int WIDTH = `SBS_BEAT_W,
  parameter int DEPTH = `SBS_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Fill side
  input wire logic inValid,
  input wire logic [WIDTH-1:0] inData,
  output logic inReady,
  // Drain side
  output logic outValid,
  output logic [WIDTH-1:0] outData,
  input wire logic outReady
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] buf_ff [0:DEPTH-1];
  logic [PW-1:0] wrPtr_ff, nxt_wrPtr;
  logic [PW-1:0] rdPtr_ff, nxt_rdPtr;
  logic [PW:0] cnt_ff, nxt_cnt;
  logic push;
  logic pop;

  always_comb begin
    push = inValid && (cnt_ff != DEPTH[PW:0]);
    pop = outReady && (cnt_ff != '0);
    nxt_wrPtr = push ? wrPtr_ff + 1'b1 : wrPtr_ff;
    nxt_rdPtr = pop ? rdPtr_ff + 1'b1 : rdPtr_ff;
    nxt_cnt = cnt_ff + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
  end

  always_ff @(posedge core_clk) begin
    if (push) begin
      buf_ff[wrPtr_ff] <= inData;
    end
    if (!nrst) begin
      wrPtr_ff <= '0;
      rdPtr_ff <= '0;
      cnt_ff <= '0;
    end else begin
      wrPtr_ff <= nxt_wrPtr;
      rdPtr_ff <= nxt_rdPtr;
      cnt_ff <= nxt_cnt;
    end
  end

  assign inReady = (cnt_ff != DEPTH[PW:0]);
  assign outValid = (cnt_ff != '0);
  assign outData = buf_ff[rdPtr_ff];
endmodule : sbs_fifo

module sbs_mem_ctrl (
  // Link
  sbs_link_if.ctl link,
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Configuration straps
  input wire logic pllOffReq,
  input wire logic singleClkReq,
  // Write request
  input wire logic wrReq,
  input wire sbs_pkg::sbs_addr_type wrAddr,
  input wire sbs_pkg::sbs_word_type wrData,
  input wire sbs_pkg::sbs_mask_type wrBytesN,
  output logic wrReady,
  // Read request
  input wire logic rdReq,
  input wire sbs_pkg::sbs_addr_type rdAddr,
  output logic rdReady,
  // Read data
  output logic rdValid,
  output sbs_pkg::sbs_beat_type rdData,
  input wire logic rdTake
);
  import sbs_pkg::*;

  // ************************************************
  // Registers
  // ************************************************
  sbs_state_type state_ff, nxt_state;
  logic kPhase_ff, nxt_kPhase;
  logic rpsN_ff, nxt_rpsN;
  logic wpsN_ff, nxt_wpsN;
  sbs_bws_type bwsN_ff, nxt_bwsN;
  sbs_addr_type addr_ff, nxt_addr;
  sbs_beat_type d_ff, nxt_d;
  sbs_word_type wrShift_ff, nxt_wrShift;
  sbs_mask_type maskShift_ff, nxt_maskShift;
  logic [2:0] beatCnt_ff, nxt_beatCnt;
  logic rdReady_ff, nxt_rdReady;
  logic wrReady_ff, nxt_wrReady;
  logic pllDisN_ff;
  logic strap_ff;
  logic fifoInReady;
  logic fifoValid;
  logic capture;

  // ************************************************
  // Next state
  // ************************************************
  always_comb begin
    nxt_kPhase = ~kPhase_ff;
    nxt_state = state_ff;
    nxt_rpsN = `SBS_RST_SEL_N;
    nxt_wpsN = `SBS_RST_SEL_N;
    nxt_bwsN = bwsN_ff;
    nxt_addr = addr_ff;
    nxt_d = d_ff;
    nxt_wrShift = wrShift_ff;
    nxt_maskShift = maskShift_ff;
    nxt_beatCnt = beatCnt_ff;
    capture = (state_ff == ST_RD) && link.rdBeatOe && fifoInReady;
    unique case (state_ff)
      ST_IDLE: begin
        // Issue one cycle ahead of the input clock rise
        if (rdReq && rdReady_ff) begin
          nxt_rpsN = 1'b0;
          nxt_addr = rdAddr;
          nxt_beatCnt = 3'h0;
          nxt_state = ST_RD;
        end else if (wrReq && wrReady_ff) begin
          nxt_wpsN = 1'b0;
          nxt_addr = wrAddr;
          nxt_wrShift = wrData;
          nxt_maskShift = wrBytesN;
          nxt_beatCnt = 3'h0;
          nxt_state = ST_WR;
        end
      end
      ST_WR: begin
        nxt_d = wrShift_ff[`SBS_BEAT_W-1:0];
        nxt_bwsN = maskShift_ff[`SBS_BWS_W-1:0];
        nxt_wrShift = {18'h0, wrShift_ff[`SBS_WORD_W-1:`SBS_BEAT_W]};
        nxt_maskShift = {2'h3, maskShift_ff[`SBS_MASK_W-1:`SBS_BWS_W]};
        nxt_beatCnt = beatCnt_ff + 3'h1;
        if (beatCnt_ff == `SBS_BEATS - 3'h1) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_RD: begin
        // Let the burst finish before the next launch
        if (capture) begin
          nxt_beatCnt = beatCnt_ff + 3'h1;
          if (beatCnt_ff == `SBS_BEATS - 3'h1) begin
            nxt_state = ST_IDLE;
          end
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
    nxt_rdReady = (nxt_state == ST_IDLE) && (state_ff == ST_IDLE) && kPhase_ff && !fifoValid;
    nxt_wrReady = (nxt_state == ST_IDLE) && (state_ff == ST_IDLE) && kPhase_ff;
  end

  // ************************************************
  // Register update
  // ************************************************
  always_ff @(posedge core_clk) begin
    pllDisN_ff <= !pllOffReq;
    strap_ff <= singleClkReq;
    addr_ff <= nxt_addr;
    d_ff <= nxt_d;
    wrShift_ff <= nxt_wrShift;
    maskShift_ff <= nxt_maskShift;
    if (!nrst) begin
      state_ff <= ST_IDLE;
      kPhase_ff <= 1'b0;
      rpsN_ff <= `SBS_RST_SEL_N;
      wpsN_ff <= `SBS_RST_SEL_N;
      bwsN_ff <= `SBS_RST_BWS_N;
      beatCnt_ff <= 3'h0;
      rdReady_ff <= 1'b0;
      wrReady_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      kPhase_ff <= nxt_kPhase;
      rpsN_ff <= nxt_rpsN;
      wpsN_ff <= nxt_wpsN;
      bwsN_ff <= nxt_bwsN;
      beatCnt_ff <= nxt_beatCnt;
      rdReady_ff <= nxt_rdReady;
      wrReady_ff <= nxt_wrReady;
    end
  end

  // ************************************************
  // Read data buffer
  // ************************************************
  sbs_fifo #(
    .WIDTH(`SBS_BEAT_W),
    .DEPTH(`SBS_FIFO_DEPTH)
  ) u_fifo (
    .core_clk(core_clk),
    .nrst(nrst),
    .inValid(capture),
    .inData(link.rdBeat),
    .inReady(fifoInReady),
    .outValid(fifoValid),
    .outData(rdData),
    .outReady(rdTake)
  );

  // ************************************************
  // Outputs
  // ************************************************
  assign link.kEn = kPhase_ff;
  assign link.readPortSelectN = rpsN_ff;
  assign link.writePortSelectN = wpsN_ff;
  assign link.byteWriteSelectN = bwsN_ff;
  assign link.addr = addr_ff;
  assign link.wrBeat = d_ff;
  assign link.pllDisableN = pllDisN_ff;
  assign link.cStrapHigh = strap_ff;
  assign rdReady = rdReady_ff;
  assign wrReady = wrReady_ff;
  assign rdValid = fifoValid;
endmodule : sbs_mem_ctrl

// ==== sbs_link_props.sv ====
// Concurrent checks on the controller-to-SRAM link signals.
// Assumes one clock domain; instantiated beside the link interface.
module sbs_link_props (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Link
  input wire logic kEn,
  input wire logic readPortSelectN,
  input wire logic writePortSelectN,
  input wire sbs_pkg::sbs_beat_type rdBeat,
  input wire logic rdBeatOe,
  input wire logic pllDisableN,
  input wire logic cStrapHigh
);
  import sbs_pkg::*;
  logic rdLaunch;
  assign rdLaunch = kEn && !readPortSelectN;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // ********************************
  // Link properties
  // ********************************
  property p_ken_alt;
    1'b1 |=> kEn != $past(kEn);
  endproperty
  a_ken_alt: assert property (p_ken_alt)
    else $error("input clock rise not every second cycle");
  property p_rd_sel_ken;
    !readPortSelectN |-> kEn;
  endproperty
  a_rd_sel_ken: assert property (p_rd_sel_ken)
    else $error("read select off the input clock rise");
  property p_wr_sel_ken;
    !writePortSelectN |-> kEn;
  endproperty
  a_wr_sel_ken: assert property (p_wr_sel_ken)
    else $error("write select off the input clock rise");
  property p_rd_spacing;
    rdLaunch |=> readPortSelectN [*3];
  endproperty
  a_rd_spacing: assert property (p_rd_spacing)
    else $error("reads launched too close");
  property p_wr_spacing;
    kEn && !writePortSelectN |=> writePortSelectN [*3];
  endproperty
  a_wr_spacing: assert property (p_wr_spacing)
    else $error("writes launched too close");
  property p_lat_on;
    rdLaunch && pllDisableN |=> !rdBeatOe [*3] ##1 rdBeatOe [*4] ##1 !rdBeatOe;
  endproperty
  a_lat_on: assert property (p_lat_on)
    else $error("read burst timing wrong with PLL on");
  property p_lat_off;
    rdLaunch && !pllDisableN |=> !rdBeatOe [*2] ##1 rdBeatOe [*4] ##1 !rdBeatOe;
  endproperty
  a_lat_off: assert property (p_lat_off)
    else $error("read burst timing wrong with PLL off");
  property p_oe_cause;
    $rose(rdBeatOe) |-> $past(rdLaunch, 4) || ($past(rdLaunch, 3) && !pllDisableN);
  endproperty
  a_oe_cause: assert property (p_oe_cause)
    else $error("read outputs driven without a read");
  property p_idle_zero;
    !rdBeatOe |-> rdBeat == 18'h0;
  endproperty
  a_idle_zero: assert property (p_idle_zero)
    else $error("read beat not cleared while floating");
  property p_straps;
    $stable(pllDisableN) && $stable(cStrapHigh);
  endproperty
  a_straps: assert property (p_straps)
    else $error("mode strap changed while running");
endmodule : sbs_link_props

// ==== sync_burst_sram_read_port_tb.sv ====
// Bench joining controller and SRAM ends through the link.
// Assumes the design files and the checker are compiled first.
module sync_burst_sram_read_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import sbs_pkg::*;
  logic core_clk, nrst, pllOffReq, singleClkReq, wrReq, rdReq, rdTake;
  logic wrReady, rdReady, rdValid, oneCycleMode, singleClkMode, rdBusy;
  sbs_addr_type wrAddr, rdAddr;
  sbs_word_type wrData, expA;
  sbs_mask_type wrBytesN;
  sbs_beat_type rdData;
  int failures, num_checks;
  localparam sbs_word_type wordA = 72'h123456789abcdef012;
  localparam sbs_word_type wordB = 72'hfedcba9876543210ed;
  localparam sbs_word_type wordN = 72'h5a5a5a5a5a5a5a5a5a;
  sbs_link_if sbs_link_if_i ();
  sbs_sram_dev sbs_sram_dev_i (.link(sbs_link_if_i), .core_clk(core_clk), .nrst(nrst),
    .oneCycleMode(oneCycleMode), .singleClkMode(singleClkMode), .rdBusy(rdBusy));
  sbs_mem_ctrl sbs_mem_ctrl_i (.link(sbs_link_if_i), .core_clk(core_clk), .nrst(nrst),
    .pllOffReq(pllOffReq), .singleClkReq(singleClkReq), .wrReq(wrReq), .wrAddr(wrAddr),
    .wrData(wrData), .wrBytesN(wrBytesN), .wrReady(wrReady), .rdReq(rdReq),
    .rdAddr(rdAddr), .rdReady(rdReady), .rdValid(rdValid), .rdData(rdData),
    .rdTake(rdTake));
  sbs_link_props sbs_link_props_i (.core_clk(core_clk), .nrst(nrst),
    .kEn(sbs_link_if_i.kEn), .readPortSelectN(sbs_link_if_i.readPortSelectN),
    .writePortSelectN(sbs_link_if_i.writePortSelectN), .rdBeat(sbs_link_if_i.rdBeat),
    .rdBeatOe(sbs_link_if_i.rdBeatOe), .pllDisableN(sbs_link_if_i.pllDisableN),
    .cStrapHigh(sbs_link_if_i.cStrapHigh));
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // ********************************
  // Helpers
  // ********************************
  task tick;
    @(posedge core_clk);
    #1;
  endtask : tick
  task check(input logic [71:0] got, input logic [71:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t %s", $time, what);
    end
  endtask : check
  task close_out;
    $display("Checks %0d, failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : close_out
  task hang(input int n);
    if (n >= 60) begin
      failures++;
      $display("[FAIL] %0t wait ran out", $time);
      close_out();
    end
  endtask : hang
  task do_reset(input logic off);
    nrst = 1'b0;
    pllOffReq = off;
    singleClkReq = off;
    repeat (20) tick();
    nrst = 1'b1;
    tick();
    check({70'h0, sbs_link_if_i.rdBeatOe, |sbs_link_if_i.rdBeat}, 72'h0, "idle link");
    check({70'h0, oneCycleMode, singleClkMode}, {70'h0, off, off}, "straps");
  endtask : do_reset
  task write_word(input sbs_addr_type a, input sbs_word_type d, input sbs_mask_type m);
    int n;
    n = 0;
    while (wrReady !== 1'b1 && n < 60) begin tick(); n++; end
    hang(n);
    wrReq = 1'b1;
    wrAddr = a;
    wrData = d;
    wrBytesN = m;
    tick();
    wrReq = 1'b0;
    repeat (8) tick();
  endtask : write_word
  task read_word(input sbs_addr_type a, input sbs_word_type exp, input int stall,
    input int lat);
    int n;
    int i;
    n = 0;
    while (rdReady !== 1'b1 && n < 60) begin tick(); n++; end
    hang(n);
    rdReq = 1'b1;
    rdAddr = a;
    tick();
    rdReq = 1'b0;
    n = 0;
    while (rdValid !== 1'b1 && n < 60) begin tick(); n++; end
    hang(n);
    check(72'(n), 72'(lat), "read latency");
    check({71'h0, rdBusy}, {71'h0, 1'b1}, "busy while beats run");
    repeat (stall) tick();
    check({71'h0, rdReady}, 72'h0, "ready with data pending");
    rdTake = 1'b1;
    for (i = 0; i < 4; i++) begin
      n = 0;
      while (rdValid !== 1'b1 && n < 60) begin tick(); n++; end
      hang(n);
      check({54'h0, rdData}, {54'h0, exp[18*i +: 18]}, "beat order");
      tick();
    end
    rdTake = 1'b0;
    check({71'h0, rdValid}, 72'h0, "fifo not empty");
    check({71'h0, rdBusy}, 72'h0, "busy after burst");
    check({71'h0, sbs_link_if_i.rdBeatOe}, 72'h0, "outputs driven after burst");
  endtask : read_word
  // ********************************
  // Scenarios
  // ********************************
  task test_plain;
    write_word(19'h00012, wordA, 8'h00);
    read_word(19'h00012, wordA, 0, 5);
    $display("plain write and read done");
  endtask : test_plain
  task test_bytes;
    int b;
    for (b = 0; b < 8; b++) expA[9*b +: 9] = b[0] ? wordA[9*b +: 9] : wordN[9*b +: 9];
    write_word(19'h00012, wordN, 8'haa);
    read_word(19'h00012, expA, 8, 5);
    $display("byte write with stalled drain done");
  endtask : test_bytes
  task test_two_addr;
    write_word(19'h7ffff, wordB, 8'h00);
    read_word(19'h7ffff, wordB, 0, 5);
    read_word(19'h00012, expA, 1, 5);
    $display("two addresses done");
  endtask : test_two_addr
  task test_pll_off;
    do_reset(1'b1);
    write_word(19'h00100, wordB, 8'h00);
    read_word(19'h00100, wordB, 2, 4);
    $display("PLL off read done");
  endtask : test_pll_off
  initial begin
    nrst = 1'b0;
    pllOffReq = 1'b0;
    singleClkReq = 1'b0;
    wrReq = 1'b0;
    rdReq = 1'b0;
    rdTake = 1'b0;
    wrAddr = 19'h0;
    rdAddr = 19'h0;
    wrData = 72'h0;
    wrBytesN = 8'hff;
    expA = wordA;
    failures = 0;
    num_checks = 0;
    do_reset(1'b0);
    test_plain();
    test_bytes();
    test_two_addr();
    test_pll_off();
    close_out();
  end
endmodule : sync_burst_sram_read_port_tb
